/* pkg/rfs_pkg.sv */
// Package holding register offsets, field positions, modes and timing for the ramped FSK sweep engine.
package rfs_pkg;
    // Register offsets as seen on the programming port.
    localparam logic [7:0] OFS_LOW_FREQ = 8'h04;
    localparam logic [7:0] OFS_HIGH_FREQ = 8'h0a;
    localparam logic [7:0] OFS_DELTA_STEP = 8'h10;
    localparam logic [7:0] OFS_RAMP_RATE = 8'h1a;
    localparam logic [7:0] OFS_CONTROL = 8'h1f;
    // Byte counts of each multi-byte register.
    localparam int WORD48_BYTES = 6;
    localparam int RATE_BYTES = 3;
    // Field positions inside the control byte.
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_TRIANGLE_BIT = 3;
    localparam int CTL_RESTART_BIT = 4;
    localparam int CTL_FULL_CLEAR_BIT = 5;
    // Widths.
    localparam int FREQ_W = 48;
    localparam int RATE_W = 20;
    // Reset values.
    localparam logic [47:0] RST_WORD48 = 48'h0;
    localparam logic [19:0] RST_RATE = 20'h0;
    localparam logic [7:0] RST_CONTROL = 8'h0;
    // Ramp rate counter ticks at half the system clock: two cycles per count.
    localparam int RATE_CLKS_PER_COUNT = 2;
    // Operating mode encodings.
    typedef enum logic [2:0] {
        RFS_MODE_SINGLE = 3'h0,
        RFS_MODE_FSK = 3'h1,
        RFS_MODE_RAMPED = 3'h2,
        RFS_MODE_CHIRP = 3'h3,
        RFS_MODE_BPSK = 3'h4
    } rfs_mode_t;
endpackage : rfs_pkg

/* rtl/rfs_rate_timer.sv */
// Ramp rate down counter producing one pulse per programmed interval.
`timescale 1ns/1ps
module rfs_rate_timer (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_run,
    input wire logic i_restart,
    input wire logic [rfs_pkg::RATE_W-1:0] i_count,
    output logic o_tick
);
    import rfs_pkg::*;

    logic [RATE_W-1:0] count;
    logic phase;
    wire at_zero = (count == '0);

    assign o_tick = i_run && phase && at_zero;

    // interval timing: one count per two clocks, reload on zero, so (N+1)*2 cycles.
    // rate reload picks up the current count at each zero, so slopes change live.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            count <= RST_RATE;
            phase <= 1'b0;
        end else if (i_restart) begin
            count <= i_count;
            phase <= 1'b0;
        end else if (i_run) begin
            phase <= ~phase;
            if (phase) begin
                count <= at_zero ? i_count : count - 1'b1;
            end
        end
    end
endmodule : rfs_rate_timer

/* rtl/rfs_sweep_engine.sv */
// Ramped FSK sweep engine: register file, step accumulator, tuning select and phase accumulator.
`timescale 1ns/1ps
module rfs_sweep_engine (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] i_rd_addr,
    output logic [7:0] o_rd_data,
    input wire logic i_update_clk,
    input wire logic i_keying_select_pin,
    output logic [rfs_pkg::FREQ_W-1:0] o_tuning_word,
    output logic [rfs_pkg::FREQ_W-1:0] o_phase_accumulator,
    output logic o_sweep_active
);
    import rfs_pkg::*;

    // Buffer registers written by the host, active copies loaded on update.
    logic [FREQ_W-1:0] buf_low, buf_high, buf_delta;
    logic [RATE_W-1:0] buf_rate;
    logic [7:0] buf_ctl;
    logic [FREQ_W-1:0] low_frequency_word, high_frequency_word, delta_step_word;
    logic [RATE_W-1:0] ramp_rate_count;
    logic [7:0] ctl;
    logic [FREQ_W-1:0] frequency_step_accumulator;
    logic [FREQ_W-1:0] phase_accumulator;
    logic [FREQ_W-1:0] tuning;
    logic upd_q, key_q, tri_q;
    logic dir_up;
    logic restart_pulse;

    // Write decoding: which byte of a multi-byte register is addressed.
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] base, input int n);
        in_range = (a >= base) && (a < base + 8'(n));
    endfunction

    wire hit_low = in_range(i_wr_addr, OFS_LOW_FREQ, WORD48_BYTES);
    wire hit_high = in_range(i_wr_addr, OFS_HIGH_FREQ, WORD48_BYTES);
    wire hit_delta = in_range(i_wr_addr, OFS_DELTA_STEP, WORD48_BYTES);
    wire hit_rate = in_range(i_wr_addr, OFS_RAMP_RATE, RATE_BYTES);
    wire hit_ctl = (i_wr_addr == OFS_CONTROL);
    // Byte index within the register; lowest address holds the most significant byte.
    wire [7:0] idx_low = 8'(WORD48_BYTES - 1) - (i_wr_addr - OFS_LOW_FREQ);
    wire [7:0] idx_high = 8'(WORD48_BYTES - 1) - (i_wr_addr - OFS_HIGH_FREQ);
    wire [7:0] idx_delta = 8'(WORD48_BYTES - 1) - (i_wr_addr - OFS_DELTA_STEP);
    wire [7:0] idx_rate = 8'(RATE_BYTES - 1) - (i_wr_addr - OFS_RAMP_RATE);

    // Buffer writes for the 48-bit words, one byte lane each.
    genvar g;
    generate
        for (g = 0; g < WORD48_BYTES; g++) begin : g_w48
            always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    buf_low[g*8 +: 8] <= 8'h00;
                    buf_high[g*8 +: 8] <= 8'h00;
                    buf_delta[g*8 +: 8] <= 8'h00;
                end else if (i_wr_en) begin
                    if (hit_low && idx_low == 8'(g)) buf_low[g*8 +: 8] <= i_wr_data;
                    if (hit_high && idx_high == 8'(g)) buf_high[g*8 +: 8] <= i_wr_data;
                    if (hit_delta && idx_delta == 8'(g)) buf_delta[g*8 +: 8] <= i_wr_data;
                end
            end
        end
    endgenerate

    // Rate and control buffer writes; the rate top byte carries only four bits.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            buf_rate <= RST_RATE;
            buf_ctl <= RST_CONTROL;
        end else if (i_wr_en) begin
            if (hit_rate && idx_rate == 8'h00) buf_rate[7:0] <= i_wr_data;
            if (hit_rate && idx_rate == 8'h01) buf_rate[15:8] <= i_wr_data;
            if (hit_rate && idx_rate == 8'h02) buf_rate[19:16] <= i_wr_data[3:0];
            if (hit_ctl) buf_ctl <= i_wr_data;
        end
    end

    // Readback of buffer registers; unmapped addresses read zero.
    wire [7:0] ridx_low = 8'(WORD48_BYTES - 1) - (i_rd_addr - OFS_LOW_FREQ);
    wire [7:0] ridx_high = 8'(WORD48_BYTES - 1) - (i_rd_addr - OFS_HIGH_FREQ);
    wire [7:0] ridx_delta = 8'(WORD48_BYTES - 1) - (i_rd_addr - OFS_DELTA_STEP);
    wire [7:0] ridx_rate = 8'(RATE_BYTES - 1) - (i_rd_addr - OFS_RAMP_RATE);
    wire [23:0] rate_ext = {4'h0, buf_rate};
    wire [7:0] rd_mux =
        in_range(i_rd_addr, OFS_LOW_FREQ, WORD48_BYTES) ? buf_low[ridx_low[2:0]*8 +: 8] :
        in_range(i_rd_addr, OFS_HIGH_FREQ, WORD48_BYTES) ? buf_high[ridx_high[2:0]*8 +: 8] :
        in_range(i_rd_addr, OFS_DELTA_STEP, WORD48_BYTES) ? buf_delta[ridx_delta[2:0]*8 +: 8] :
        in_range(i_rd_addr, OFS_RAMP_RATE, RATE_BYTES) ? rate_ext[ridx_rate[1:0]*8 +: 8] :
        (i_rd_addr == OFS_CONTROL) ? buf_ctl : 8'h00;

    // Read data is registered so it stays clean for the port.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) o_rd_data <= 8'h00;
        else o_rd_data <= rd_mux;
    end

    // Update clock edge detect; the update input is treated as synchronous.
    wire update_edge = i_update_clk && !upd_q;

    // update transfer: buffers move to the active core only on an update rising edge.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            low_frequency_word <= RST_WORD48;
            high_frequency_word <= RST_WORD48;
            delta_step_word <= RST_WORD48;
            ramp_rate_count <= RST_RATE;
            ctl <= RST_CONTROL;
            upd_q <= 1'b0;
        end else begin
            upd_q <= i_update_clk;
            if (update_edge) begin
                low_frequency_word <= buf_low;
                high_frequency_word <= buf_high;
                delta_step_word <= buf_delta;
                ramp_rate_count <= buf_rate;
                ctl <= buf_ctl;
            end
        end
    end

    // mode decode from three control bits.
    wire [2:0] mode_bits = ctl[CTL_MODE_LSB +: 3];
    wire mode_ramped = (mode_bits == RFS_MODE_RAMPED);
    wire mode_chirp = (mode_bits == RFS_MODE_CHIRP);
    wire mode_fsk = (mode_bits == RFS_MODE_FSK);
    wire triangle = ctl[CTL_TRIANGLE_BIT] && mode_ramped;
    wire restart_bit = ctl[CTL_RESTART_BIT];
    wire full_clear = ctl[CTL_FULL_CLEAR_BIT];

    // restart one-shot: one cycle on each update edge while the bit is set.
    // held restart retriggers on every update edge.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) restart_pulse <= 1'b0;
        else restart_pulse <= update_edge && buf_ctl[CTL_RESTART_BIT];
    end

    // Edge detection of keying pin and triangle bit.
    wire key_edge = (i_keying_select_pin != key_q);
    wire tri_rise = triangle && !tri_q;

    // Sweep span: distance from low to high word.
    wire [FREQ_W-1:0] span = high_frequency_word - low_frequency_word;
    wire [FREQ_W:0] acc_sum = {1'b0, frequency_step_accumulator} + {1'b0, delta_step_word};
    // clamp: in ramped mode the step never runs past the span, so output lands on the destination.
    wire at_dest = mode_ramped && (frequency_step_accumulator >= span);
    wire [FREQ_W-1:0] next_step =
        (mode_ramped && acc_sum >= {1'b0, span}) ? span : acc_sum[FREQ_W-1:0];

    // Direction state: up means heading toward the high word.
    // triangle reverses at each end and ignores the keying pin.
    // triangle start follows the keying level at the rising edge.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dir_up <= 1'b0;
            key_q <= 1'b0;
            tri_q <= 1'b0;
        end else begin
            key_q <= i_keying_select_pin;
            tri_q <= triangle;
            // A low keying level starts at the low word, so the first leg heads up.
            if (tri_rise) dir_up <= !i_keying_select_pin;
            else if (triangle && at_dest) dir_up <= ~dir_up;
            // keying reversal is immediate even mid-sweep.
            else if (!triangle) dir_up <= i_keying_select_pin;
        end
    end

    // Step accumulator measures distance travelled from the start point this leg.
    // On reversal the distance left becomes span minus distance travelled.
    wire reverse = (!triangle && key_edge && mode_ramped) || (triangle && at_dest);
    // rate counter runs after a keying change until the destination.
    // the counter stops once the destination is reached.
    // Triangle keeps the counter running through each turnaround.
    wire run = (mode_ramped && (!at_dest || triangle)) || mode_chirp;
    wire tick;

    rfs_rate_timer u_rate_timer (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(run && !full_clear),
        .i_restart(reverse || restart_pulse || tri_rise),
        .i_count(ramp_rate_count),
        .o_tick(tick)
    );

    // step accumulation on each rate pulse.
    // full clear holds the step accumulator at zero.
    // on reversal the step restarts mirrored so frequency is continuous.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) frequency_step_accumulator <= RST_WORD48;
        else if (full_clear || restart_pulse || tri_rise) frequency_step_accumulator <= '0;
        else if (reverse) frequency_step_accumulator <= span - frequency_step_accumulator;
        else if (tick) frequency_step_accumulator <= next_step;
    end

    // tuning select: low plus step going up, high minus step going down.
    // output walks through intermediate frequencies as the step grows.
    // chirp runs unbounded from the low word.
    // at the destination the step is frozen, so the word holds.
    always_comb begin
        tuning = low_frequency_word;
        if (full_clear) tuning = '0;
        else if (mode_ramped && dir_up) tuning = low_frequency_word + frequency_step_accumulator;
        else if (mode_ramped) tuning = high_frequency_word - frequency_step_accumulator;
        else if (mode_chirp) tuning = low_frequency_word + frequency_step_accumulator;
        else if (mode_fsk && i_keying_select_pin) tuning = high_frequency_word;
    end

    // Phase accumulator integrates the tuning word; full clear holds it at zero.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_accumulator <= RST_WORD48;
            o_tuning_word <= RST_WORD48;
        end else begin
            o_tuning_word <= tuning;
            if (full_clear) phase_accumulator <= '0;
            else phase_accumulator <= phase_accumulator + tuning;
        end
    end

    assign o_phase_accumulator = phase_accumulator;
    assign o_sweep_active = run && !full_clear;
endmodule : rfs_sweep_engine

/* verif/rfs_host_model.sv */
// Host model that programs the engine byte by byte and drives the keying pin.
`timescale 1ns/1ps
module rfs_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_en,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [7:0] o_rd_addr,
    output logic o_update_clk,
    output logic o_keying
);
    // Everything starts low; all changes happen on the falling edge.
    initial begin
        o_wr_en = 1'b0;
        o_wr_addr = 8'h00;
        o_wr_data = 8'h00;
        o_rd_addr = 8'h00;
        o_update_clk = 1'b0;
        o_keying = 1'b0;
    end
    // Released data is inverted so nothing can lean on a stale byte.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_wr_en = 1'b1;
        o_wr_addr = a;
        o_wr_data = d;
        @(negedge i_core_clk);
        o_wr_en = 1'b0;
        o_wr_data = ~d;
    endtask : wr
    // whole words, most significant byte first.
    task automatic wr48(input logic [7:0] a, input logic [47:0] v);
        for (int i = 0; i < 6; i++) begin
            wr(a + 8'(i), v[47 - 8 * i -: 8]);
        end
    endtask : wr48
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_rd_addr = a;
        @(negedge i_core_clk);
        d = i_rd_data;
    endtask : rd
    // one update edge, spaced two cycles.
    task automatic upd();
        @(negedge i_core_clk);
        o_update_clk = 1'b1;
        @(negedge i_core_clk);
        o_update_clk = 1'b0;
    endtask : upd
    task automatic ctl(input logic [7:0] c);
        wr(rfs_pkg::OFS_CONTROL, c);
        upd();
    endtask : ctl
    task automatic key(input logic k);
        @(negedge i_core_clk);
        o_keying = k;
    endtask : key
endmodule : rfs_host_model

/* verif/rfs_sweep_assertions.sv */
// Port-level concurrent checks for the ramped sweep engine.
`timescale 1ns/1ps
module rfs_sweep_assertions (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] i_rd_addr,
    input wire logic [7:0] o_rd_data,
    input wire logic i_update_clk,
    input wire logic i_keying_select_pin,
    input wire logic [rfs_pkg::FREQ_W-1:0] o_tuning_word,
    input wire logic [rfs_pkg::FREQ_W-1:0] o_phase_accumulator,
    input wire logic o_sweep_active
);
    import rfs_pkg::*;
    logic [7:0] ctl_buf;
    logic [7:0] ctl_act;
    logic [3:0] upd_hist;
    wire upd_edge = i_update_clk && !upd_hist[0];
    wire quiet = !i_update_clk && (upd_hist == 4'h0);
    wire clr_on = ctl_act[CTL_FULL_CLEAR_BIT];
    wire ramp_on = (ctl_act[2:0] == RFS_MODE_RAMPED) && !clr_on;
    wire tri_on = ramp_on && ctl_act[CTL_TRIANGLE_BIT];
    wire single_on = (ctl_act[2:0] == RFS_MODE_SINGLE);
    // Control byte mirror; updates are kept in a history so checks skip their settling.
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl_buf <= RST_CONTROL;
            ctl_act <= RST_CONTROL;
            upd_hist <= 4'h0;
        end else begin
            if (i_wr_en && (i_wr_addr == OFS_CONTROL)) ctl_buf <= i_wr_data;
            if (upd_edge) ctl_act <= ctl_buf;
            upd_hist <= {upd_hist[2:0], i_update_clk};
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    idle_hold_a: assert property (
        quiet && !o_sweep_active && $past(!o_sweep_active) |=> $stable(o_tuning_word))
        else $error("tuning word moved while the sweep was stopped");
    tick_space_a: assert property (
        $changed(o_tuning_word) && o_sweep_active && quiet ##1 quiet [*3]
        |-> o_tuning_word == $past(o_tuning_word, 3)) else $error("sweep steps too close");
    rate_start_a: assert property (
        ramp_on && !ctl_act[CTL_TRIANGLE_BIT] && $changed(i_keying_select_pin)
        |-> ##[0:2] o_sweep_active) else $error("keying change did not start the counter");
    full_clear_a: assert property (
        clr_on && $past(clr_on, 3) |-> o_tuning_word == 48'h0 && o_phase_accumulator == 48'h0)
        else $error("accumulators not held clear");
    single_tone_a: assert property (
        single_on && $past(single_on) && $past(single_on, 2) |-> !o_sweep_active)
        else $error("sweep running outside the ramped modes");
    triangle_run_a: assert property (
        tri_on && $past(tri_on, 3) |-> o_sweep_active) else $error("triangle sweep halted");
    read_ctl_a: assert property (
        $past(i_rd_addr) == OFS_CONTROL |-> o_rd_data == $past(ctl_buf))
        else $error("control byte read back wrong");
    unmapped_read_a: assert property (
        $past(i_rd_addr) == 8'h30 |-> o_rd_data == 8'h00) else $error("unmapped read not zero");
endmodule : rfs_sweep_assertions
bind rfs_sweep_engine rfs_sweep_assertions rfs_sweep_assertions_inst (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
    .i_update_clk(i_update_clk), .i_keying_select_pin(i_keying_select_pin),
    .o_tuning_word(o_tuning_word), .o_phase_accumulator(o_phase_accumulator),
    .o_sweep_active(o_sweep_active));

/* verif/tb.sv */
// Self-checking bench for the ramped sweep engine.
`timescale 1ns/1ps
module tb;
    import rfs_pkg::*;
    localparam logic [47:0] LOW = 48'h1000;
    localparam logic [47:0] HIGH = 48'h1048;
    localparam logic [47:0] STEP = 48'h10;
    localparam int RATE_N = 1;
    localparam int GAP = (RATE_N + 1) * RATE_CLKS_PER_COUNT;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic wr_en, upd_clk, keying, active;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data, rd_val;
    logic [47:0] tuning, phase;
    int bad_count = 0;
    int cmp_count = 0;
    int steps;
    always #5 i_core_clk = ~i_core_clk;
    rfs_host_model host (.i_core_clk(i_core_clk), .i_rd_data(rd_data), .o_wr_en(wr_en),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr),
        .o_update_clk(upd_clk), .o_keying(keying));
    rfs_sweep_engine rfs_sweep_engine_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr),
        .o_rd_data(rd_data), .i_update_clk(upd_clk), .i_keying_select_pin(keying),
        .o_tuning_word(tuning), .o_phase_accumulator(phase), .o_sweep_active(active));
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // Follows a sweep, checking each step, the clamp at the end and the tick spacing.
    task automatic sweep(input logic [47:0] dest, input logic up, input int stop_n);
        logic [47:0] prev;
        logic [47:0] exp;
        int last;
        int t;
        prev = tuning;
        last = -1;
        steps = 0;
        for (t = 0; t < 400 && tuning !== dest && steps != stop_n; t++) begin
            @(negedge i_core_clk);
            if (tuning !== prev) begin
                exp = up ? ((prev + STEP > dest) ? dest : prev + STEP)
                         : ((prev < dest + STEP) ? dest : prev - STEP);
                check("tuning step", tuning, exp);
                if (last >= 0) check("tick gap", 48'(t - last), 48'(GAP));
                last = t;
                prev = tuning;
                steps++;
            end
        end
        if (t >= 400) begin
            bad_count++;
            close_out();
        end
    endtask : sweep
    task automatic wait_low();
        for (int t = 0; t < 8 && tuning !== LOW; t++) @(negedge i_core_clk);
        check("restart to start word", tuning, LOW);
    endtask : wait_low
    initial begin
        repeat (5) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        check("tuning after reset", tuning, 48'h0);
        for (int m = 0; m < 5; m++) begin
            host.ctl(8'(m));
            host.rd(OFS_CONTROL, rd_val);
            check("mode readback", 48'(rd_val), 48'(m));
        end
        host.rd(8'h30, rd_val);
        check("unmapped read", 48'(rd_val), 48'h0);
        host.wr48(OFS_LOW_FREQ, LOW);
        host.wr48(OFS_HIGH_FREQ, HIGH);
        host.wr48(OFS_DELTA_STEP, STEP);
        host.wr(OFS_RAMP_RATE, 8'h00);
        host.wr(OFS_RAMP_RATE + 8'h01, 8'h00);
        host.wr(OFS_RAMP_RATE + 8'h02, 8'(RATE_N));
        host.rd(OFS_DELTA_STEP + 8'h05, rd_val);
        check("delta readback", 48'(rd_val), STEP);
        host.ctl(8'h02);
        host.ctl(8'h12);
        host.ctl(8'h02);
        sweep(LOW, 1'b0, 99);
        check("start at low word", tuning, LOW);
        host.key(1'b1);
        sweep(HIGH, 1'b1, 99);
        check("intermediate steps", 48'(steps), 48'h5);
        repeat (20) @(negedge i_core_clk);
        check("dwell at high", tuning, HIGH);
        check("counter stopped", 48'(active), 48'h0);
        host.key(1'b0);
        sweep(LOW, 1'b0, 2);
        host.key(1'b1);
        sweep(HIGH, 1'b1, 99);
        // Restart held high fires on each update, even at the destination.
        host.wr(OFS_CONTROL, 8'h12);
        for (int r = 0; r < 2; r++) begin
            host.upd();
            wait_low();
            sweep(HIGH, 1'b1, 99);
            check("steps after restart", 48'(steps), 48'h5);
        end
        host.ctl(8'h22);
        repeat (4) @(negedge i_core_clk);
        check("tuning cleared", tuning, 48'h0);
        repeat (10) @(negedge i_core_clk);
        check("phase held clear", phase, 48'h0);
        host.ctl(8'h02);
        repeat (10) @(negedge i_core_clk);
        check("phase resumes", 48'(phase != 48'h0), 48'h1);
        sweep(HIGH, 1'b1, 99);
        host.key(1'b0);
        sweep(LOW, 1'b0, 99);
        // Triangle starts from the low word and ignores the keying pin.
        host.ctl(8'h0a);
        host.key(1'b1);
        sweep(HIGH, 1'b1, 99);
        sweep(LOW, 1'b0, 99);
        check("triangle steps", 48'(steps), 48'h5);
        close_out();
    end
endmodule : tb
